// ### rtl/close_onto_fault_guard.sv
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module close_onto_fault_guard #(
  parameter int unsigned CYCLES_PER_MS = close_onto_fault_pkg::CYCLES_PER_MS
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic arm_in,
  input wire logic block_in,
  input wire logic fault_start_in,
  input wire close_onto_fault_pkg::reg_req_t req_in,
  output logic [31:0] rdata_out,
  output logic init_out,
  output logic active_out,
  output logic trip_out,
  output logic blocked_out,
  output close_onto_fault_pkg::cond_t guard_condition_out,
  output close_onto_fault_pkg::event_t event_out
);
  typedef struct packed {
    close_onto_fault_pkg::cond_t cond;
    close_onto_fault_pkg::cond_t shown;
    logic [3:0] flags;
    logic arm_q;
    logic [20:0] elapsed;
    logic [31:0] now_ms;
    logic [7:0] ctrl;
    logic [7:0] mask;
    logic [7:0][20:0] win;
    logic [3:0][15:0] cnt;
    logic [3:0] log_sel;
    logic [3:0] log_wptr;
    logic [11:0] log_valid;
    close_onto_fault_pkg::log_entry_t [11:0] log;
    close_onto_fault_pkg::event_t ev;
    logic [31:0] rdata;
  } state_t;

  state_t st;
  state_t next_st;
  logic tick;
  logic rise;
  logic force_en;
  logic [2:0] group;
  logic [20:0] win_now;
  logic [20:0] remain;
  logic [3:0] next_flags;
  logic [3:0] on_edges;
  logic [3:0] clr;
  logic [1:0] first_on;
  close_onto_fault_pkg::log_entry_t sel_entry;

  ms_tick #(.CYCLES(CYCLES_PER_MS)) tick_gen (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .tick_out(tick)
  );

  // Live view of window length from the selected group
  assign force_en = st.ctrl[close_onto_fault_pkg::CTRL_FORCE_EN];
  assign group = st.ctrl[close_onto_fault_pkg::CTRL_GROUP +: 3];
  assign win_now = st.win[group];
  // Remaining time floors at zero when a group change shrinks the window
  assign remain = (st.elapsed >= win_now) ? 21'h0_0000 : win_now - st.elapsed;
  assign sel_entry = st.log[st.log_sel];
  assign rise = arm_in & ~st.arm_q;
  assign clr = (req_in.wr && req_in.addr == close_onto_fault_pkg::ADDR_CNT_CLR) ?
               req_in.wdata[3:0] : 4'h0;

  // Next state of the whole block
  always_comb begin
    next_st = st;
    next_st.arm_q = arm_in;
    next_st.ev.on = 4'h0;
    next_st.ev.off = 4'h0;
    next_st.ev.stamp = st.now_ms;
    if (tick) begin
      next_st.now_ms = st.now_ms + 32'h0000_0001;
    end
    // Condition machine; forcing below only changes what is shown
    case (st.cond)
      close_onto_fault_pkg::COND_NORMAL, close_onto_fault_pkg::COND_BLOCKED: begin
        if (block_in) begin
          next_st.cond = close_onto_fault_pkg::COND_BLOCKED;
        end else if (rise) begin
          next_st.cond = close_onto_fault_pkg::COND_INIT;
        end else begin
          next_st.cond = close_onto_fault_pkg::COND_NORMAL;
        end
      end
      close_onto_fault_pkg::COND_INIT: begin
        next_st.elapsed = 21'h0_0000;
        next_st.cond = close_onto_fault_pkg::COND_ACTIVE;
      end
      close_onto_fault_pkg::COND_ACTIVE: begin
        if (fault_start_in) begin
          next_st.cond = close_onto_fault_pkg::COND_TRIP;
        end else if (st.elapsed >= win_now) begin
          next_st.cond = close_onto_fault_pkg::COND_NORMAL;
        end else if (tick) begin
          next_st.elapsed = st.elapsed + 21'h0_0001;
        end
      end
      close_onto_fault_pkg::COND_TRIP: begin
        if (!fault_start_in) begin
          next_st.cond = close_onto_fault_pkg::COND_NORMAL;
        end
      end
      default: begin
        next_st.cond = close_onto_fault_pkg::COND_NORMAL;
      end
    endcase
    next_st.shown = next_st.cond;
    if (force_en) begin
      case (close_onto_fault_pkg::force_t'(st.ctrl[close_onto_fault_pkg::CTRL_FORCE_SEL +: 2]))
        close_onto_fault_pkg::FORCE_BLOCKED: next_st.shown = close_onto_fault_pkg::COND_BLOCKED;
        close_onto_fault_pkg::FORCE_ACTIVE: next_st.shown = close_onto_fault_pkg::COND_ACTIVE;
        close_onto_fault_pkg::FORCE_TRIP: next_st.shown = close_onto_fault_pkg::COND_TRIP;
        default: next_st.shown = close_onto_fault_pkg::COND_NORMAL;
      endcase
    end
    // Flags and events follow the shown condition
    next_flags = 4'h0;
    next_flags[close_onto_fault_pkg::FLAG_INIT] = next_st.shown == close_onto_fault_pkg::COND_INIT;
    next_flags[close_onto_fault_pkg::FLAG_BLOCK] =
      next_st.shown == close_onto_fault_pkg::COND_BLOCKED;
    next_flags[close_onto_fault_pkg::FLAG_ACTIVE] =
      next_st.shown == close_onto_fault_pkg::COND_ACTIVE;
    next_flags[close_onto_fault_pkg::FLAG_TRIP] = next_st.shown == close_onto_fault_pkg::COND_TRIP;
    next_st.flags = next_flags;
    on_edges = next_flags & ~st.flags;
    next_st.ev.on = on_edges & st.mask[3:0];
    next_st.ev.off = ~next_flags & st.flags & st.mask[close_onto_fault_pkg::MASK_OFF +: 4];
    for (int i = 0; i < 4; i++) begin
      if (on_edges[i]) begin
        next_st.cnt[i] = clr[i] ? 16'h0001 : st.cnt[i] + 16'h0001;
      end else if (clr[i]) begin
        next_st.cnt[i] = 16'h0000;
      end
    end
    // Highest flag turning on this cycle goes to the log
    first_on = 2'(close_onto_fault_pkg::FLAG_INIT);
    for (int i = 0; i < 4; i++) begin
      if (on_edges[i]) begin
        first_on = 2'(i);
      end
    end
    if (on_edges != 4'h0) begin
      next_st.log[st.log_wptr] = '{st.now_ms, first_on, group, remain, st.elapsed};
      next_st.log_valid[st.log_wptr] = 1'b1;
      next_st.log_wptr = (st.log_wptr == close_onto_fault_pkg::LOG_LAST) ?
                         4'h0 : st.log_wptr + 4'h1;
    end
    // Register writes
    if (req_in.wr) begin
      case (req_in.addr)
        close_onto_fault_pkg::ADDR_CTRL: next_st.ctrl = req_in.wdata[7:0];
        close_onto_fault_pkg::ADDR_MASK: next_st.mask = req_in.wdata[7:0];
        close_onto_fault_pkg::ADDR_LOG_SEL: begin
          if (req_in.wdata[3:0] <= close_onto_fault_pkg::LOG_LAST) begin
            next_st.log_sel = req_in.wdata[3:0];
          end
        end
        default: begin
          // window length clamped to the maximum
          if (req_in.addr[5:3] == close_onto_fault_pkg::ADDR_WIN0[5:3]) begin
            next_st.win[req_in.addr[2:0]] = (req_in.wdata > 32'(close_onto_fault_pkg::WIN_MAX_MS)) ?
              close_onto_fault_pkg::WIN_MAX : req_in.wdata[20:0];
          end
        end
      endcase
    end
    // Register reads, answered the cycle after the strobe
    next_st.rdata = 32'h0000_0000;
    if (req_in.rd) begin
      case (req_in.addr)
        close_onto_fault_pkg::ADDR_CTRL: next_st.rdata = {24'h00_0000, st.ctrl};
        close_onto_fault_pkg::ADDR_MASK: next_st.rdata = {24'h00_0000, st.mask};
        close_onto_fault_pkg::ADDR_STATUS: next_st.rdata = {29'h0000_0000, st.shown};
        close_onto_fault_pkg::ADDR_REMAIN: next_st.rdata = {11'h000, remain};
        close_onto_fault_pkg::ADDR_ELAPSED: next_st.rdata = {11'h000, st.elapsed};
        close_onto_fault_pkg::ADDR_LOG_SEL: next_st.rdata = {28'h000_0000, st.log_sel};
        close_onto_fault_pkg::ADDR_LOG_PTR: next_st.rdata = {20'h0_0000, st.log_valid};
        close_onto_fault_pkg::ADDR_LOG_TIME: next_st.rdata = sel_entry.stamp;
        close_onto_fault_pkg::ADDR_LOG_INFO:
          next_st.rdata = {26'h000_0000, st.log_valid[st.log_sel], sel_entry.group,
                           sel_entry.event_id};
        close_onto_fault_pkg::ADDR_LOG_REMAIN: next_st.rdata = {11'h000, sel_entry.remain};
        close_onto_fault_pkg::ADDR_LOG_ACTIVE: next_st.rdata = {11'h000, sel_entry.active};
        default: begin
          if (req_in.addr[5:3] == close_onto_fault_pkg::ADDR_WIN0[5:3]) begin
            next_st.rdata = {11'h000, st.win[req_in.addr[2:0]]};
          end else if (req_in.addr[5:2] == close_onto_fault_pkg::ADDR_CNT0[5:2] + 4'h0 &&
                       req_in.addr >= close_onto_fault_pkg::ADDR_CNT0) begin
            next_st.rdata = {16'h0000, st.cnt[2'(req_in.addr - close_onto_fault_pkg::ADDR_CNT0)]};
          end else if (req_in.addr == close_onto_fault_pkg::ADDR_CNT0 + 6'h02 ||
                       req_in.addr == close_onto_fault_pkg::ADDR_CNT0 + 6'h03) begin
            next_st.rdata = {16'h0000, st.cnt[2'(req_in.addr - close_onto_fault_pkg::ADDR_CNT0)]};
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      // Settings return to defaults, history and counters clear
      st <= '0;
      st.win <= {8{close_onto_fault_pkg::WIN_RST}};
      st.mask <= close_onto_fault_pkg::MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign rdata_out = st.rdata;
  assign guard_condition_out = st.shown;
  assign init_out = st.flags[close_onto_fault_pkg::FLAG_INIT];
  assign blocked_out = st.flags[close_onto_fault_pkg::FLAG_BLOCK];
  assign active_out = st.flags[close_onto_fault_pkg::FLAG_ACTIVE];
  assign trip_out = st.flags[close_onto_fault_pkg::FLAG_TRIP];
  assign event_out = st.ev;

  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  a_edge_starts_init: assert property (
    (st.cond == close_onto_fault_pkg::COND_NORMAL) && rise && !block_in
    |=> st.cond == close_onto_fault_pkg::COND_INIT) else $error("arm edge did not start");
  a_level_no_rearm: assert property (
    arm_in && st.arm_q |=> st.cond != close_onto_fault_pkg::COND_INIT)
    else $error("held arm level re-armed");
  a_fault_trips_now: assert property (
    (st.cond == close_onto_fault_pkg::COND_ACTIVE) && fault_start_in && !force_en
    |=> trip_out && guard_condition_out == close_onto_fault_pkg::COND_TRIP)
    else $error("fault start did not trip");
  a_block_no_start: assert property (
    block_in |=> st.cond != close_onto_fault_pkg::COND_INIT) else $error("started while blocked");
  a_window_clamped: assert property (
    st.win[group] <= close_onto_fault_pkg::WIN_MAX) else $error("window above maximum");
  a_force_overrides: assert property (
    force_en && st.ctrl[2:1] == 2'h3 ##1 force_en
    |-> guard_condition_out == close_onto_fault_pkg::COND_TRIP) else $error("force ignored");
  a_count_trip_on: assert property (
    !trip_out ##1 trip_out && !$past(clr[3])
    |-> st.cnt[3] == $past(st.cnt[3]) + 16'h0001) else $error("trip count missed");
  a_log_wraps: assert property (
    on_edges != 4'h0 && st.log_wptr == close_onto_fault_pkg::LOG_LAST
    |=> st.log_wptr == 4'h0) else $error("log pointer did not wrap");
  a_expire_normal: assert property (
    st.cond == close_onto_fault_pkg::COND_ACTIVE && !fault_start_in && st.elapsed >= win_now
    |=> st.cond == close_onto_fault_pkg::COND_NORMAL) else $error("window did not expire");
  a_tick_counts: assert property (
    st.cond == close_onto_fault_pkg::COND_ACTIVE && tick && !fault_start_in &&
    st.elapsed < win_now |=> st.elapsed == $past(st.elapsed) + 21'h0_0001)
    else $error("elapsed did not advance");
  // Trip stays up while the start signal stays high
  a_trip_holds: assert property (
    st.cond == close_onto_fault_pkg::COND_TRIP && fault_start_in
    |=> st.cond == close_onto_fault_pkg::COND_TRIP) else $error("trip dropped early");
  // Init lasts one cycle and opens the window with nothing elapsed
  a_init_to_active: assert property (
    st.cond == close_onto_fault_pkg::COND_INIT
    |=> st.cond == close_onto_fault_pkg::COND_ACTIVE && st.elapsed == 21'h0_0000)
    else $error("init did not open window");
  // Read data is zero outside the slot after a read strobe
  a_rdata_idle: assert property (
    !req_in.rd |=> rdata_out == 32'h0000_0000) else $error("read data outside read slot");
  // ON and OFF of one event never leave together
  a_event_exclusive: assert property (
    (event_out.on & event_out.off) == 4'h0) else $error("event on and off together");
  // Every ON event moves the log pointer one slot
  a_log_advance: assert property (
    on_edges != 4'h0 && st.log_wptr != close_onto_fault_pkg::LOG_LAST
    |=> st.log_wptr == $past(st.log_wptr) + 4'h1) else $error("log pointer skipped");
  // Block input drives an idle guard into Blocked
  a_block_shows: assert property (
    block_in && !force_en && st.cond == close_onto_fault_pkg::COND_NORMAL
    |=> blocked_out) else $error("block not shown");

  c_arm_expire: cover property (
    st.cond == close_onto_fault_pkg::COND_ACTIVE ##1 st.cond == close_onto_fault_pkg::COND_NORMAL);
  c_arm_trip: cover property (
    st.cond == close_onto_fault_pkg::COND_ACTIVE ##1 st.cond == close_onto_fault_pkg::COND_TRIP);
  c_blocked_edge: cover property (block_in && rise);
  // Log wrap and a live group change
  c_log_wrap: cover property (
    on_edges != 4'h0 && st.log_wptr == close_onto_fault_pkg::LOG_LAST);
  c_live_group: cover property (
    st.cond == close_onto_fault_pkg::COND_ACTIVE && req_in.wr &&
    req_in.addr == close_onto_fault_pkg::ADDR_CTRL);
endmodule : close_onto_fault_guard

// ### rtl/close_onto_fault_pkg.sv
// Function
// - Only a rising edge of the arming input starts the window.
// - Fault start during the window trips at once, no added delay.
// - Asserted block input stops the window from starting.
// - Window length programmable 0 to 1800.000 s, default 1.000 s.
// - Window length follows the selected setting group, also while running.
// - Forcing enable lets a selector force Normal, Blocked, Active or Trip.
// - Read-only condition shows Normal, Init, Active, Trip or Blocked.
// - ON and OFF events for Init, Block, Active, Trip, masked per event.
// - Separate clearable counters of Init, Blocked, Active and Trip.
// - Circular log keeps the twelve newest ON entries.
// - Log entry: ms timestamp, event, group, time remaining, time active.
package close_onto_fault_pkg;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_PERIOD_NS = 1_000_000;
  localparam int unsigned CYCLES_PER_MS = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned WIN_MAX_MS = 1_800_000;
  localparam logic [20:0] WIN_MAX = 21'h1b_7740;
  localparam logic [20:0] WIN_RST = 21'h0_03e8;
  localparam int unsigned LOG_DEPTH = 12;
  localparam logic [3:0] LOG_LAST = 4'hb;
  // Register word addresses
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_MASK = 6'h01;
  localparam logic [5:0] ADDR_CNT_CLR = 6'h02;
  localparam logic [5:0] ADDR_STATUS = 6'h03;
  localparam logic [5:0] ADDR_REMAIN = 6'h04;
  localparam logic [5:0] ADDR_ELAPSED = 6'h05;
  localparam logic [5:0] ADDR_CNT0 = 6'h06;
  localparam logic [5:0] ADDR_LOG_SEL = 6'h0a;
  localparam logic [5:0] ADDR_LOG_PTR = 6'h0b;
  localparam logic [5:0] ADDR_LOG_TIME = 6'h0c;
  localparam logic [5:0] ADDR_LOG_INFO = 6'h0d;
  localparam logic [5:0] ADDR_LOG_REMAIN = 6'h0e;
  localparam logic [5:0] ADDR_LOG_ACTIVE = 6'h0f;
  localparam logic [5:0] ADDR_WIN0 = 6'h10;
  // Field positions and reset values
  localparam int unsigned CTRL_FORCE_EN = 0;
  localparam int unsigned CTRL_FORCE_SEL = 1;
  localparam int unsigned CTRL_GROUP = 3;
  localparam int unsigned MASK_OFF = 4;
  localparam int unsigned INFO_GROUP = 2;
  localparam logic [7:0] MASK_RST = 8'hff;
  // Flag bit order in every four-bit event vector
  localparam int unsigned FLAG_INIT = 0;
  localparam int unsigned FLAG_BLOCK = 1;
  localparam int unsigned FLAG_ACTIVE = 2;
  localparam int unsigned FLAG_TRIP = 3;

  typedef enum logic [2:0] {
    COND_NORMAL = 3'b000,
    COND_INIT = 3'b001,
    COND_ACTIVE = 3'b010,
    COND_TRIP = 3'b011,
    COND_BLOCKED = 3'b100
  } cond_t;

  typedef enum logic [1:0] {
    FORCE_NORMAL = 2'b00,
    FORCE_BLOCKED = 2'b01,
    FORCE_ACTIVE = 2'b10,
    FORCE_TRIP = 2'b11
  } force_t;

  typedef struct packed {
    logic [31:0] stamp;
    logic [1:0] event_id;
    logic [2:0] group;
    logic [20:0] remain;
    logic [20:0] active;
  } log_entry_t;

  typedef struct packed {
    logic [3:0] on;
    logic [3:0] off;
    logic [31:0] stamp;
  } event_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : close_onto_fault_pkg

// ### rtl/ms_tick.sv
`timescale 1ns/1ps
// One-cycle pulse every CYCLES clocks
module ms_tick #(
  parameter int unsigned CYCLES = 100_000
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  output logic tick_out
);
  logic [31:0] count;

  // Divider restarts from zero on reset
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      count <= 32'h0000_0000;
      tick_out <= 1'b0;
    end else begin
      tick_out <= (count == 32'(CYCLES - 1));
      count <= (count == 32'(CYCLES - 1)) ? 32'h0000_0000 : count + 32'h0000_0001;
    end
  end
endmodule : ms_tick

// ### verification/breaker_side_model.sv
`timescale 1ns/1ps
// Breaker close contact and protection start relay facing the guard
module breaker_side_model (
  input wire logic core_clk_in,
  input wire logic close_cmd_in,
  input wire logic fault_cmd_in,
  output logic arm_out,
  output logic fault_start_out
);
  // Both lines follow their commands one clock later, as relay logic would
  always_ff @(posedge core_clk_in) begin
    arm_out <= close_cmd_in;
    fault_start_out <= fault_cmd_in;
  end
endmodule : breaker_side_model

// ### verification/tb_close_onto_fault_guard.sv
`timescale 1ns/1ps
module tb_close_onto_fault_guard;
  localparam int unsigned CPM = 4;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic close_cmd = 1'b0;
  logic fault_cmd = 1'b0;
  logic block = 1'b0;
  logic arm;
  logic fault_start;
  close_onto_fault_pkg::reg_req_t req = '0;
  logic [31:0] rdata;
  logic init;
  logic active;
  logic trip;
  logic blocked;
  close_onto_fault_pkg::cond_t cond;
  close_onto_fault_pkg::event_t evt;
  int error_cnt = 0;
  int n_compared = 0;
  logic [31:0] v;
  int n;
  logic [31:0] w;
  int cyc = 0;

  // Free-running 100 MHz clock
  always #5 core_clk_in = ~core_clk_in;

  // Edges since reset release, for judging event time stamps
  always @(posedge core_clk_in) begin
    if (!rst_in) begin
      cyc <= cyc + 1;
    end
  end

  breaker_side_model far_side (.core_clk_in(core_clk_in), .close_cmd_in(close_cmd),
    .fault_cmd_in(fault_cmd), .arm_out(arm), .fault_start_out(fault_start));

  close_onto_fault_guard #(.CYCLES_PER_MS(CPM)) DUT (.core_clk_in(core_clk_in),
    .rst_in(rst_in), .arm_in(arm), .block_in(block), .fault_start_in(fault_start),
    .req_in(req), .rdata_out(rdata), .init_out(init), .active_out(active),
    .trip_out(trip), .blocked_out(blocked), .guard_condition_out(cond), .event_out(evt));

  task step;
    @(posedge core_clk_in);
    #1;
  endtask : step

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  task wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_in);
    req <= '0;
  endtask : wr

  task rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge core_clk_in);
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_in);
    req <= '0;
    #1;
    d = rdata;
  endtask : rd

  // Steps until the condition shows c, at most lim cycles; cnt gives the steps taken
  task wait_cond(input close_onto_fault_pkg::cond_t c, input int lim, output int cnt);
    cnt = 0;
    while (cond !== c && cnt < lim) begin
      step;
      cnt++;
    end
    chk(32'(cond), 32'(c));
  endtask : wait_cond

  task t_reset;
    chk(32'(cond), 32'(close_onto_fault_pkg::COND_NORMAL));
    rd(close_onto_fault_pkg::ADDR_WIN0, v);
    chk(v, 32'h0000_03e8);
    rd(close_onto_fault_pkg::ADDR_MASK, v);
    chk(v, 32'h0000_00ff);
    rd(6'h3f, v);
    chk(v, 32'h0000_0000);
  endtask : t_reset

  task t_expire;
    wr(close_onto_fault_pkg::ADDR_WIN0, 32'h0000_0002);
    @(posedge core_clk_in);
    close_cmd <= 1'b1;
    wait_cond(close_onto_fault_pkg::COND_INIT, 10, n);
    step;
    chk(32'(active), 32'h0000_0001);
    wait_cond(close_onto_fault_pkg::COND_NORMAL, 100, n);
    chk(32'(n >= CPM && n <= 3 * CPM), 32'h0000_0001);
    repeat (20) step;
    chk(32'(init | active), 32'h0000_0000);
    @(posedge core_clk_in);
    close_cmd <= 1'b0;
    repeat (3) step;
  endtask : t_expire

  task t_trip;
    wr(close_onto_fault_pkg::ADDR_WIN0, 32'h0000_0064);
    @(posedge core_clk_in);
    close_cmd <= 1'b1;
    wait_cond(close_onto_fault_pkg::COND_ACTIVE, 10, n);
    @(posedge core_clk_in);
    fault_cmd <= 1'b1;
    step;
    step;
    chk(32'(trip), 32'h0000_0001);
    chk(32'(evt.stamp <= 32'(cyc / CPM) && evt.stamp + 32'h0000_0001 >= 32'(cyc / CPM)),
        32'h0000_0001);
    chk(32'(evt.on[close_onto_fault_pkg::FLAG_TRIP]), 32'h0000_0001);
    chk(32'(evt.off[close_onto_fault_pkg::FLAG_ACTIVE]), 32'h0000_0001);
    chk(32'(cond), 32'(close_onto_fault_pkg::COND_TRIP));
    rd(close_onto_fault_pkg::ADDR_CNT0 + 6'h03, v);
    chk(v, 32'h0000_0001);
    @(posedge core_clk_in);
    fault_cmd <= 1'b0;
    close_cmd <= 1'b0;
    wait_cond(close_onto_fault_pkg::COND_NORMAL, 600, n);
    wr(close_onto_fault_pkg::ADDR_CNT_CLR, 32'h0000_000f);
    rd(close_onto_fault_pkg::ADDR_CNT0 + 6'h03, v);
    chk(v, 32'h0000_0000);
    rd(close_onto_fault_pkg::ADDR_LOG_PTR, v);
    chk(v, 32'h0000_001f);
    wr(close_onto_fault_pkg::ADDR_LOG_SEL, 32'h0000_0004);
    rd(close_onto_fault_pkg::ADDR_LOG_INFO, v);
    chk(v, 32'h0000_0023);
    rd(close_onto_fault_pkg::ADDR_LOG_REMAIN, v);
    rd(close_onto_fault_pkg::ADDR_LOG_ACTIVE, w);
    chk(v + w, 32'h0000_0064);
  endtask : t_trip

  task t_block;
    @(posedge core_clk_in);
    block <= 1'b1;
    step;
    step;
    chk(32'(cond), 32'(close_onto_fault_pkg::COND_BLOCKED));
    chk(32'(blocked), 32'h0000_0001);
    @(posedge core_clk_in);
    close_cmd <= 1'b1;
    repeat (10) step;
    chk(32'(init | active), 32'h0000_0000);
    @(posedge core_clk_in);
    block <= 1'b0;
    close_cmd <= 1'b0;
    repeat (3) step;
  endtask : t_block

  task t_group;
    wr(close_onto_fault_pkg::ADDR_WIN0 + 6'h02, 32'h001b_7741);
    rd(close_onto_fault_pkg::ADDR_WIN0 + 6'h02, v);
    chk(v, 32'h001b_7740);
    wr(close_onto_fault_pkg::ADDR_WIN0 + 6'h01, 32'h0000_0000);
    wr(close_onto_fault_pkg::ADDR_CTRL, 32'h0000_0008);
    @(posedge core_clk_in);
    close_cmd <= 1'b1;
    wait_cond(close_onto_fault_pkg::COND_INIT, 10, n);
    n = 0;
    repeat (10) begin
      step;
      n += int'(active);
    end
    chk(32'(n), 32'h0000_0001);
    @(posedge core_clk_in);
    close_cmd <= 1'b0;
    wr(close_onto_fault_pkg::ADDR_CTRL, 32'h0000_0000);
    // Group switch while the window runs: group 1 has a zero window
    @(posedge core_clk_in);
    close_cmd <= 1'b1;
    wait_cond(close_onto_fault_pkg::COND_ACTIVE, 10, n);
    wr(close_onto_fault_pkg::ADDR_CTRL, 32'h0000_0008);
    wait_cond(close_onto_fault_pkg::COND_NORMAL, 3, n);
    @(posedge core_clk_in);
    close_cmd <= 1'b0;
    wr(close_onto_fault_pkg::ADDR_CTRL, 32'h0000_0000);
  endtask : t_group

  task t_force;
    close_onto_fault_pkg::cond_t exp_c[4];
    exp_c = '{close_onto_fault_pkg::COND_NORMAL, close_onto_fault_pkg::COND_BLOCKED,
      close_onto_fault_pkg::COND_ACTIVE, close_onto_fault_pkg::COND_TRIP};
    for (int i = 0; i < 4; i++) begin
      wr(close_onto_fault_pkg::ADDR_CTRL, 32'(i * 2 + 1));
      repeat (3) step;
      chk(32'(cond), 32'(exp_c[i]));
    end
    rd(close_onto_fault_pkg::ADDR_LOG_PTR, v);
    chk(v, 32'h0000_0fff);
    wr(close_onto_fault_pkg::ADDR_LOG_SEL, 32'h0000_0000);
    rd(close_onto_fault_pkg::ADDR_LOG_INFO, v);
    chk(v, 32'h0000_0023);
    wr(close_onto_fault_pkg::ADDR_CTRL, 32'h0000_0000);
    repeat (3) step;
  endtask : t_force

  task end_sim;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // Watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    #300000;
    error_cnt++;
    end_sim;
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk_in);
    rst_in <= 1'b0;
    step;
    t_reset;
    t_expire;
    t_trip;
    t_block;
    t_group;
    t_force;
    end_sim;
  end
endmodule : tb_close_onto_fault_guard
